/* inc/smiagg_pkg.sv */
package smiagg_pkg;

	// Register indices; the byte address is four times the index.
	localparam logic [7:0] IDX_ENABLE_A  = 8'h_00B4;
	localparam logic [7:0] IDX_ENABLE_B  = 8'h_00B5;
	localparam logic [7:0] IDX_STATUS_A  = 8'h_00B6;
	localparam logic [7:0] IDX_STATUS_B  = 8'h_00B7;
	localparam logic [7:0] IDX_RSVD_STBY = 8'h_00B8;
	localparam logic [7:0] IDX_PIN_MUX   = 8'h_00C0;
	localparam logic [7:0] IDX_FORCE_DC  = 8'h_00C1;
	localparam logic [7:0] IDX_EVT_STAT  = 8'h_00D0;
	localparam logic [7:0] IDX_EVT_MASK  = 8'h_00D1;

	// Reset values.
	localparam logic [7:0] RST_ENABLE    = 8'h_0000;
	localparam logic [7:0] RST_PIN_MUX   = 8'h_0002;
	localparam logic       RST_FORCE_DC  = 1'b1;

	// Writable or readable bits of the enable and pin multiplex registers.
	localparam logic [7:0] MASK_ENABLE_A = 8'h_009E;
	localparam logic [7:0] MASK_ENABLE_B = 8'h_0057;
	localparam logic [7:0] MASK_PIN_MUX  = 8'h_000A;

	// Field positions in the first enable and status registers.
	localparam int BIT_PARPORT  = 1;
	localparam int BIT_UART_B   = 2;
	localparam int BIT_UART_A   = 3;
	localparam int BIT_FLOPPY   = 4;
	localparam int BIT_WATCHDOG = 7;

	// Field positions in the second enable and status registers.
	localparam int BIT_MOUSE    = 0;
	localparam int BIT_KEYBOARD = 1;
	localparam int BIT_IR_ACT   = 2;
	localparam int BIT_KBC_LINE = 4;
	localparam int BIT_FWD_SIRQ = 6;

	// Field positions in the pin multiplex and disk change registers.
	localparam int BIT_DMA3_SEL = 1;
	localparam int BIT_KBC_SEL  = 3;
	localparam int BIT_FORCE_DC = 0;

	// Event status and mask layout.
	localparam int EVT_W = 9;
	localparam int EVT_IR_ACT = 8;

	// Request lines from the peripherals, all active high.
	typedef struct packed {
		logic parport_req;
		logic uart_b_req;
		logic uart_a_req;
		logic floppy_req;
		logic watchdog_req;
		logic mouse_req;
		logic keyboard_req;
		logic kbc_port_line;
	} smiagg_src_s;

	// Drive-side floppy signals, all active low.
	typedef struct packed {
		logic floppy_step_n;
		logic drive0_select_n;
		logic disk_changed_in_n;
	} smiagg_fdd_s;

endpackage

/* verilog/smiagg_top.sv */
// Function
// R01 - First enable register gates five sources.
// R02 - Second enable gates mouse, keyboard, IR.
// R03 - Enable bit four routes port line.
// R04 - Enable bit six forwards to serial IRQ.
// R05 - First status follows source request levels.
// R06 - Second status follows mouse, keyboard, line.
// R07 - IR bit set on selected pin transition.
// R08 - Reading second status clears IR bit.
// R09 - Enables and status reset to zero.
// R10 - Pin mux selects, reset value 0x02.
// R11 - Disk change latch set by writing one.
// R12 - Step or drive select clears latch.
// R13 - Disk change flag from select, latch, input.
// R14 - Interrupt low when enabled status set.
// R15 - Reserved bits read zero, ignore writes.
`timescale 1ns/100ps
`default_nettype none

module smiagg_top #(
	parameter int ADDR_W = 12
) (
	// Clock and reset.
	input  wire logic                      clk_i,
	input  wire logic                      rst_i,
	// Wishbone classic slave.
	input  wire logic                      cyc_i,
	input  wire logic                      stb_i,
	input  wire logic                      we_i,
	input  wire logic [ADDR_W-1:0]         adr_i,
	input  wire logic [3:0]                sel_i,
	input  wire logic [31:0]               dat_i,
	output logic      [31:0]               dat_o,
	output logic                           ack_o,
	// Peripheral sources and IR pins.
	input  wire smiagg_pkg::smiagg_src_s   src_i,
	input  wire logic                      uart_b_rx_pin_i,
	input  wire logic                      infrared_rx_pin_i,
	input  wire logic                      ir_pin_select_i,
	// Floppy drive signals.
	input  wire smiagg_pkg::smiagg_fdd_s   fdd_i,
	output logic                           disk_changed_flag_o,
	// Interrupt and multiplex outputs.
	output logic                           mgmt_irq_n_o,
	output logic                           serial_irq_req_o,
	output logic                           irq_o,
	output logic                           dma3_sel_o,
	output logic                           kbc_pin_sel_o
);

	// The index field sits at address bits 9:2, so narrower buses fail.
	if (ADDR_W < 10) begin : g_bad_addr
		$error("smiagg_top: ADDR_W must be at least 10");
	end

	// Local names for the package constants. Nothing is imported, so
	// each alias points back at the single definition in the package;
	// the values themselves are never restated here.

	// Register indices decoded from the bus address.
	localparam logic [7:0] IDX_ENABLE_A  = smiagg_pkg::IDX_ENABLE_A;
	localparam logic [7:0] IDX_ENABLE_B  = smiagg_pkg::IDX_ENABLE_B;
	localparam logic [7:0] IDX_STATUS_A  = smiagg_pkg::IDX_STATUS_A;
	localparam logic [7:0] IDX_STATUS_B  = smiagg_pkg::IDX_STATUS_B;
	localparam logic [7:0] IDX_PIN_MUX   = smiagg_pkg::IDX_PIN_MUX;
	localparam logic [7:0] IDX_FORCE_DC  = smiagg_pkg::IDX_FORCE_DC;
	localparam logic [7:0] IDX_EVT_STAT  = smiagg_pkg::IDX_EVT_STAT;
	localparam logic [7:0] IDX_EVT_MASK  = smiagg_pkg::IDX_EVT_MASK;

	// Reset values.
	localparam logic [7:0] RST_ENABLE    = smiagg_pkg::RST_ENABLE;
	localparam logic [7:0] RST_PIN_MUX   = smiagg_pkg::RST_PIN_MUX;
	localparam logic       RST_FORCE_DC  = smiagg_pkg::RST_FORCE_DC;

	// Writable bits; everything else is reserved and reads zero.
	localparam logic [7:0] MASK_ENABLE_A = smiagg_pkg::MASK_ENABLE_A;
	localparam logic [7:0] MASK_ENABLE_B = smiagg_pkg::MASK_ENABLE_B;
	localparam logic [7:0] MASK_PIN_MUX  = smiagg_pkg::MASK_PIN_MUX;

	// Field positions in the first enable and status pair.
	localparam int BIT_PARPORT  = smiagg_pkg::BIT_PARPORT;
	localparam int BIT_UART_B   = smiagg_pkg::BIT_UART_B;
	localparam int BIT_UART_A   = smiagg_pkg::BIT_UART_A;
	localparam int BIT_FLOPPY   = smiagg_pkg::BIT_FLOPPY;
	localparam int BIT_WATCHDOG = smiagg_pkg::BIT_WATCHDOG;

	// Field positions in the second enable and status pair.
	localparam int BIT_MOUSE    = smiagg_pkg::BIT_MOUSE;
	localparam int BIT_KEYBOARD = smiagg_pkg::BIT_KEYBOARD;
	localparam int BIT_IR_ACT   = smiagg_pkg::BIT_IR_ACT;
	localparam int BIT_KBC_LINE = smiagg_pkg::BIT_KBC_LINE;
	localparam int BIT_FWD_SIRQ = smiagg_pkg::BIT_FWD_SIRQ;

	// Pin multiplex and disk change fields.
	localparam int BIT_DMA3_SEL = smiagg_pkg::BIT_DMA3_SEL;
	localparam int BIT_KBC_SEL  = smiagg_pkg::BIT_KBC_SEL;
	localparam int BIT_FORCE_DC = smiagg_pkg::BIT_FORCE_DC;

	// Event register layout; the IR transition sits above the sources.
	localparam int EVT_W        = smiagg_pkg::EVT_W;
	localparam int EVT_IR_ACT   = smiagg_pkg::EVT_IR_ACT;

	// Register index of a byte address.
	function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] a);
		reg_index = a[9:2];
	endfunction

	// Widen an eight-bit register to the bus word.
	function automatic logic [31:0] word8(input logic [7:0] v);
		word8 = {24'h_0000_00, v};
	endfunction

	// Register state.
	logic [7:0]       enable_a_reg;
	logic [7:0]       enable_b_reg;
	logic [7:0]       pin_mux_reg;
	logic             force_dc_reg;
	logic             ir_act_reg;
	logic             ir_prev_reg;
	logic [EVT_W-1:0] evt_stat_reg;
	logic [EVT_W-1:0] evt_mask_reg;
	logic [7:0]       src_prev_reg;
	logic             ack_reg;
	logic [31:0]      dat_reg;
	logic             irq_n_reg;
	logic             sirq_reg;
	logic             irq_reg;
	logic             dc_flag_reg;

	// Decoded bus terms.
	logic        req;
	logic        do_write;
	logic        do_read;
	logic [7:0]  idx;
	logic [7:0]  wbyte;
	logic        wr_lane;

	// Combinational status views.
	logic [7:0]       status_a;
	logic [7:0]       status_b;
	logic             ir_sel;
	logic             ir_edge;
	logic [7:0]       src_vec;
	logic [EVT_W-1:0] evt_set;
	logic             ir_clr;
	logic             grp_active;

	// Bus request; a write or a read acts on the edge that sees ack.
	assign req      = cyc_i && stb_i;
	assign do_write = req && ack_reg && we_i;
	assign do_read  = req && ack_reg && !we_i;
	assign idx      = reg_index(adr_i);
	assign wbyte    = dat_i[7:0];
	assign wr_lane  = do_write && sel_i[0];

	// Acknowledge one cycle after the request and drop it the next.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= req && !ack_reg;
		end
	end

	// R05 status levels
	always_comb begin
		status_a = 8'h_0000;
		status_a[BIT_PARPORT]  = src_i.parport_req;
		status_a[BIT_UART_B]   = src_i.uart_b_req;
		status_a[BIT_UART_A]   = src_i.uart_a_req;
		status_a[BIT_FLOPPY]   = src_i.floppy_req;
		status_a[BIT_WATCHDOG] = src_i.watchdog_req;
	end

	// R06 status levels
	always_comb begin
		status_b = 8'h_0000;
		status_b[BIT_MOUSE]    = src_i.mouse_req;
		status_b[BIT_KEYBOARD] = src_i.keyboard_req;
		status_b[BIT_IR_ACT]   = ir_act_reg;
		status_b[BIT_KBC_LINE] = src_i.kbc_port_line;
	end

	// R07 pin after mux
	assign ir_sel  = ir_pin_select_i ? infrared_rx_pin_i : uart_b_rx_pin_i;
	assign ir_edge = ir_sel != ir_prev_reg;

	// Previous IR level for the transition detector.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ir_prev_reg <= 1'b0;
		end else begin
			ir_prev_reg <= ir_sel;
		end
	end

	// R08 read clears
	assign ir_clr = do_read && (idx == IDX_STATUS_B);

	// IR activity flag; a transition in the clearing cycle still sets it.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ir_act_reg <= 1'b0;
		end else if (ir_edge) begin
			ir_act_reg <= 1'b1;
		end else if (ir_clr) begin
			ir_act_reg <= 1'b0;
		end
	end

	// R01 enable register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			// R09 enables reset zero
			enable_a_reg <= RST_ENABLE;
		end else if (wr_lane && idx == IDX_ENABLE_A) begin
			// R15 reserved masked
			enable_a_reg <= wbyte & MASK_ENABLE_A;
		end
	end

	// R02 enable register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			enable_b_reg <= RST_ENABLE;
		end else if (wr_lane && idx == IDX_ENABLE_B) begin
			// R15 reserved masked
			enable_b_reg <= wbyte & MASK_ENABLE_B;
		end
	end

	// R10 pin multiplex
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_mux_reg <= RST_PIN_MUX;
		end else if (wr_lane && idx == IDX_PIN_MUX) begin
			pin_mux_reg <= wbyte & MASK_PIN_MUX;
		end
	end

	// Forced disk change latch; software can only set it.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			force_dc_reg <= RST_FORCE_DC;
		end else if (wr_lane && idx == IDX_FORCE_DC
		             && wbyte[BIT_FORCE_DC]) begin
			// R11 write one sets
			force_dc_reg <= 1'b1;
		end else if (!fdd_i.floppy_step_n || !fdd_i.drive0_select_n) begin
			// R12 step or select
			force_dc_reg <= 1'b0;
		end
	end

	// R13 disk change flag
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dc_flag_reg <= 1'b0;
		end else begin
			dc_flag_reg <= (fdd_i.drive0_select_n && force_dc_reg)
			               || fdd_i.disk_changed_in_n;
		end
	end

	// R14 group interrupt
	always_comb begin
		grp_active = |(status_a & enable_a_reg);
		// R02 second group
		grp_active = grp_active
		             || (status_b[BIT_MOUSE] && enable_b_reg[BIT_MOUSE])
		             || (status_b[BIT_KEYBOARD]
		                 && enable_b_reg[BIT_KEYBOARD])
		             || (status_b[BIT_IR_ACT] && enable_b_reg[BIT_IR_ACT]);
		// R03 port line route
		grp_active = grp_active
		             || (status_b[BIT_KBC_LINE]
		                 && enable_b_reg[BIT_KBC_LINE]);
	end

	// Registered interrupt outputs, one cycle behind the sources.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_n_reg <= 1'b1;
			sirq_reg  <= 1'b0;
		end else begin
			irq_n_reg <= !grp_active;
			// R04 serial forward
			sirq_reg  <= grp_active && enable_b_reg[BIT_FWD_SIRQ];
		end
	end

	// Source vector for rising-edge events, in event layout order.
	assign src_vec = src_i;

	// Previous source levels.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			src_prev_reg <= 8'h_0000;
		end else begin
			src_prev_reg <= src_vec;
		end
	end

	// A source rising, or any IR transition, is an event.
	always_comb begin
		evt_set = '0;
		evt_set[7:0] = src_vec & ~src_prev_reg;
		evt_set[EVT_IR_ACT] = ir_edge;
	end

	// Sticky events, cleared by writing one; a new event wins.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			evt_stat_reg <= '0;
		end else if (do_write && idx == IDX_EVT_STAT) begin
			evt_stat_reg <= (evt_stat_reg & ~dat_i[EVT_W-1:0]) | evt_set;
		end else begin
			evt_stat_reg <= evt_stat_reg | evt_set;
		end
	end

	// Event mask; both byte lanes may be written separately.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			evt_mask_reg <= '0;
		end else if (do_write && idx == IDX_EVT_MASK) begin
			if (sel_i[0]) begin
				evt_mask_reg[7:0] <= dat_i[7:0];
			end
			if (sel_i[1]) begin
				evt_mask_reg[EVT_IR_ACT] <= dat_i[EVT_IR_ACT];
			end
		end
	end

	// Level interrupt from unmasked events.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= |(evt_stat_reg & evt_mask_reg);
		end
	end

	// Read data is captured with the ack; unmapped indices read zero.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_reg <= 32'h_0000_0000;
		end else if (req && !ack_reg) begin
			case (idx)
				IDX_ENABLE_A: dat_reg <= word8(enable_a_reg);
				IDX_ENABLE_B: dat_reg <= word8(enable_b_reg);
				IDX_STATUS_A: dat_reg <= word8(status_a);
				IDX_STATUS_B: dat_reg <= word8(status_b);
				IDX_PIN_MUX:  dat_reg <= word8(pin_mux_reg);
				IDX_FORCE_DC: dat_reg <= word8({7'h_00, force_dc_reg});
				IDX_EVT_STAT: dat_reg <= {23'h_0, evt_stat_reg};
				IDX_EVT_MASK: dat_reg <= {23'h_0, evt_mask_reg};
				default:      dat_reg <= 32'h_0000_0000;
			endcase
		end
	end

	// Outputs.
	assign dat_o               = dat_reg;
	assign ack_o               = ack_reg;
	assign mgmt_irq_n_o        = irq_n_reg;
	assign serial_irq_req_o    = sirq_reg;
	assign irq_o               = irq_reg;
	assign dma3_sel_o          = pin_mux_reg[BIT_DMA3_SEL];
	assign kbc_pin_sel_o       = pin_mux_reg[BIT_KBC_SEL];
	assign disk_changed_flag_o = dc_flag_reg;

endmodule

`default_nettype wire

/* test/smiagg_assertions.sv */
`timescale 1ns/100ps
`default_nettype none

module smiagg_assertions #(
	parameter int ADDR_W = 12
) (
	// Clock, reset and bus.
	input wire logic			clk_i,
	input wire logic			rst_i,
	input wire logic			cyc_i,
	input wire logic			stb_i,
	input wire logic			we_i,
	input wire logic [ADDR_W-1:0]	adr_i,
	input wire logic [3:0]		sel_i,
	input wire logic [31:0]		dat_i,
	input wire logic			ack_o,
	// Sources, pins and outputs.
	input wire smiagg_pkg::smiagg_src_s	src_i,
	input wire logic			uart_b_rx_pin_i,
	input wire logic			infrared_rx_pin_i,
	input wire logic			ir_pin_select_i,
	input wire smiagg_pkg::smiagg_fdd_s	fdd_i,
	input wire logic			disk_changed_flag_o,
	input wire logic			mgmt_irq_n_o,
	input wire logic			serial_irq_req_o,
	input wire logic			irq_o,
	input wire logic			dma3_sel_o,
	input wire logic			kbc_pin_sel_o
);
	logic [7:0]	en_a, en_b, idx, s;
	logic		wr, wc1, rd7, grp, pin;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	// Decoded bus events and the level the IR bit is excluded from.
	assign idx = adr_i[9:2];
	assign s = src_i;
	assign wr = cyc_i && stb_i && we_i && ack_o && sel_i[0];
	assign wc1 = wr && idx == smiagg_pkg::IDX_FORCE_DC && dat_i[0];
	assign rd7 = cyc_i && stb_i && !we_i && ack_o && idx == 8'hB7;
	assign pin = ir_pin_select_i ? infrared_rx_pin_i : uart_b_rx_pin_i;
	assign grp = |(en_a & {s[3], 2'b00, s[4], s[5], s[6], s[7], 1'b0})
		|| |(en_b & {3'b000, s[0], 2'b00, s[1], s[2]});

	// Shadow enables; they change only at the acknowledged write.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			en_a <= 8'h00;
			en_b <= 8'h00;
		end else if (wr && idx == smiagg_pkg::IDX_ENABLE_A) begin
			en_a <= dat_i[7:0] & smiagg_pkg::MASK_ENABLE_A;
		end else if (wr && idx == smiagg_pkg::IDX_ENABLE_B) begin
			en_b <= dat_i[7:0] & smiagg_pkg::MASK_ENABLE_B;
		end
	end

	chk_group_out: assert property (
		!en_b[2] |=> mgmt_irq_n_o == !$past(grp))
		else $error("group interrupt level wrong");
	chk_serial_fwd: assert property (
		1'b1 |=> serial_irq_req_o == ($past(en_b[6]) && !mgmt_irq_n_o))
		else $error("serial forward wrong");
	chk_ack_pulse: assert property (
		cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
		else $error("ack not a single pulse");
	chk_ir_set: assert property (
		en_b[2] && $changed(pin) |-> ##[1:3] !mgmt_irq_n_o)
		else $error("IR transition not seen");
	chk_ir_clear: assert property (
		rd7 && !grp && $stable(pin) ##1 !grp && $stable(pin)
		|=> mgmt_irq_n_o)
		else $error("IR bit not cleared by read");
	chk_dc_input: assert property (
		fdd_i.disk_changed_in_n |=> disk_changed_flag_o)
		else $error("disk change input not passed");
	chk_dc_select: assert property (
		!fdd_i.drive0_select_n && !fdd_i.disk_changed_in_n
		|=> !disk_changed_flag_o)
		else $error("disk change flag not gated");
	chk_latch_step: assert property (
		!fdd_i.floppy_step_n && !wc1 ##1 fdd_i.drive0_select_n
		&& !fdd_i.disk_changed_in_n |=> !disk_changed_flag_o)
		else $error("step did not clear latch");
	chk_reset_vals: assert property (
		$fell(rst_i) |-> mgmt_irq_n_o && !serial_irq_req_o && !irq_o
		&& dma3_sel_o && !kbc_pin_sel_o)
		else $error("reset values wrong");
endmodule

bind smiagg_top smiagg_assertions #(.ADDR_W(ADDR_W)) u_chk (.*);

`default_nettype wire

/* test/smiagg_partner.sv */
`timescale 1ns/100ps
`default_nettype none

module smiagg_partner (
	// Commands from the bench.
	input wire logic		clk_i,
	input wire logic [7:0]	want_src_i,
	input wire logic [2:0]	want_fdd_i,
	input wire logic [1:0]	want_ir_i,
	// Peripheral and drive lines.
	output var logic [7:0]	src_o = 8'h00,
	output var logic [2:0]	fdd_o = 3'h6,
	output var logic [1:0]	ir_o = 2'h0
);
	// Lines move just after an edge, so a request is held as a level.
	always_ff @(posedge clk_i) begin
		src_o <= want_src_i;
		fdd_o <= want_fdd_i;
		ir_o <= want_ir_i;
	end
endmodule

`default_nettype wire

/* test/tb_smi_event_aggregator.sv */
`timescale 1ns/100ps
`default_nettype none

module tb_smi_event_aggregator;
	logic	clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0;
	logic	we_i = 1'b0, ir_pin_select_i = 1'b1, ack_o, irq_o;
	logic	mgmt_irq_n_o, serial_irq_req_o, disk_changed_flag_o;
	logic	dma3_sel_o, kbc_pin_sel_o, uart_b_rx_pin_i, infrared_rx_pin_i;
	logic [11:0]	adr_i = 12'h000;
	logic [3:0]	sel_i = 4'h1;
	logic [31:0]	dat_i = 32'h0, dat_o, rdat;
	logic [7:0]	want_src = 8'h00;
	logic [2:0]	want_fdd = 3'h6;
	logic [1:0]	want_ir = 2'h0;
	smiagg_pkg::smiagg_src_s	src_i;
	smiagg_pkg::smiagg_fdd_s	fdd_i;
	int	miscompares = 0, total_checks = 0;
	logic [7:0]	ridx [8] = '{8'hB4, 8'hB5, 8'hB6, 8'hB7, 8'hB8, 8'hC0,
		8'hC1, 8'h20};
	logic [7:0]	rexp [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02,
		8'h01, 8'h00};
	logic [7:0]	widx [5] = '{8'hB4, 8'hB5, 8'hC0, 8'hB6, 8'hB8};
	logic [7:0]	wexp [5] = '{8'h9E, 8'h57, 8'h0A, 8'h00, 8'h00};
	logic [7:0]	sen [8] = '{8'h10, 8'h02, 8'h01, 8'h80, 8'h10, 8'h08,
		8'h04, 8'h02};

	smiagg_top #(.ADDR_W(12)) dut (.*);
	smiagg_partner peer (.clk_i(clk_i), .want_src_i(want_src),
		.want_fdd_i(want_fdd), .want_ir_i(want_ir), .src_o(src_i),
		.fdd_o(fdd_i), .ir_o({uart_b_rx_pin_i, infrared_rx_pin_i}));

	// Free-running 10 MHz clock.
	always #50 clk_i = ~clk_i;

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	task automatic chk_reg(input logic [31:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== {24'h0, exp}) begin
			miscompares++;
			$display("[FAIL] %0t register %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_pin(input logic got, input logic exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t output %b expected %b", $time, got, exp);
		end
	endtask

	// One classic cycle; the wait is bounded so a dead slave ends the run.
	task automatic bus(input logic w, input logic [7:0] idx, wd);
		int n = 0;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= {2'h0, idx, 2'h0};
		dat_i <= {24'h0, wd};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 50);
		rdat = dat_o;
		if (n >= 50) begin
			miscompares++;
			$display("[FAIL] %0t bus wait timed out", $time);
			print_verdict();
		end
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] idx);
		bus(1'b0, idx, 8'h00);
	endtask

	// Main sequence: reset values, masks, sources, events, IR, disk.
	initial begin
		tick(10);
		rst_i <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			rd(ridx[i]);
			chk_reg(rdat, rexp[i]);
		end
		chk_pin(dma3_sel_o, 1'b1);
		for (int i = 0; i < 5; i++) begin
			bus(1'b1, widx[i], 8'hFF);
			rd(widx[i]);
			chk_reg(rdat, wexp[i]);
		end
		chk_pin(kbc_pin_sel_o, 1'b1);
		chk_pin(dma3_sel_o, 1'b1);
		bus(1'b1, 8'hB4, 8'h00);
		bus(1'b1, 8'hB5, 8'h00);
		for (int i = 0; i < 8; i++) begin
			want_src <= 8'h01 << i;
			tick(4);
			chk_pin(mgmt_irq_n_o, 1'b1);
			rd(i < 3 ? 8'hB7 : 8'hB6);
			chk_reg(rdat, sen[i]);
			bus(1'b1, i < 3 ? 8'hB5 : 8'hB4, sen[i]);
			tick(3);
			chk_pin(mgmt_irq_n_o, 1'b0);
			want_src <= 8'h00;
			tick(4);
			chk_pin(mgmt_irq_n_o, 1'b1);
			bus(1'b1, i < 3 ? 8'hB5 : 8'hB4, 8'h00);
		end
		bus(1'b1, smiagg_pkg::IDX_EVT_STAT, 8'hFF);
		bus(1'b1, smiagg_pkg::IDX_EVT_MASK, 8'h04);
		bus(1'b1, 8'hB5, 8'h41);
		want_src <= 8'h04;
		tick(4);
		chk_pin(irq_o, 1'b1);
		chk_pin(serial_irq_req_o, 1'b1);
		bus(1'b1, 8'hB5, 8'h01);
		bus(1'b1, smiagg_pkg::IDX_EVT_MASK, 8'h00);
		tick(3);
		chk_pin(serial_irq_req_o, 1'b0);
		chk_pin(irq_o, 1'b0);
		bus(1'b1, smiagg_pkg::IDX_EVT_MASK, 8'h04);
		bus(1'b1, smiagg_pkg::IDX_EVT_STAT, 8'h04);
		tick(3);
		chk_pin(irq_o, 1'b0);
		rd(smiagg_pkg::IDX_EVT_STAT);
		chk_reg(rdat, 8'h00);
		want_src <= 8'h00;
		bus(1'b1, 8'hB5, 8'h04);
		want_ir <= 2'h2;
		tick(4);
		chk_pin(mgmt_irq_n_o, 1'b1);
		want_ir <= 2'h3;
		tick(4);
		chk_pin(mgmt_irq_n_o, 1'b0);
		rd(8'hB7);
		chk_reg(rdat, 8'h04);
		tick(3);
		chk_pin(mgmt_irq_n_o, 1'b1);
		ir_pin_select_i <= 1'b0;
		want_ir <= 2'h1;
		tick(4);
		rd(8'hB7);
		chk_reg(rdat, 8'h04);
		bus(1'b1, 8'hB5, 8'h00);
		chk_pin(disk_changed_flag_o, 1'b1);
		want_fdd <= 3'h4;
		tick(2);
		want_fdd <= 3'h6;
		tick(4);
		chk_pin(disk_changed_flag_o, 1'b0);
		bus(1'b1, 8'hC1, 8'h01);
		tick(3);
		chk_pin(disk_changed_flag_o, 1'b1);
		bus(1'b1, 8'hC1, 8'h00);
		rd(8'hC1);
		chk_reg(rdat, 8'h01);
		want_fdd <= 3'h2;
		tick(2);
		want_fdd <= 3'h7;
		tick(4);
		chk_pin(disk_changed_flag_o, 1'b1);
		rd(8'hC1);
		chk_reg(rdat, 8'h00);
		print_verdict();
	end
endmodule

`default_nettype wire
